// file: src/fifo_chan_pkg.sv
/*
 * Constants, field layout and types for one serial channel's FIFO data
 * handling block: register offsets, control and command bits, pool sizes,
 * line-side symbol kinds and the transmit sequencer states.
 * Assumes a 32-bit APB register bus and a line coder on the same clock.
 */
// Functional notes
// - Power-down keeps all state, halts the channel and forwards no interrupts.
// - Oscillator runs when its power-down bit is 0; shaper used when disable bit 0 and oscillator runs.
// - Two 32-byte transmit pools; writable status or pool-ready allows 32 bytes.
// - Frame or I-frame command starts a packet, optional preambles first; async frame only.
// - Without message end, pool-ready repeats whenever at most 32 bytes remain.
// - Packet modes close with CRC and flag; shared-flag lets back-to-back packets share.
// - Packet-mode FIFO empty before message end sends abort and raises underrun.
// - Transmit reset aborts the current packet, block or character while powered up, unless a sequencer step in that cycle moves the state on.
// - Bisync message end appends the internal CRC when CRC generation is enabled.
// - Bisync underrun before message end ends the block with idle and raises underrun.
// - Two 32-byte receive pools; pool-full at threshold, packet modes only mid-message.
// - Message end interrupt when a whole message or its final part is stored.
// - Message end stores length in count registers and a status byte, kept or appended.
// - Character modes: enabled termination character ends the block with its interrupt.
// - Character modes: receive FIFO read command gives access without interrupt and ends the block.
// - Character modes may store parity, parity error and async framing error per byte.
// - End condition stores last block length in low count; 1, 2, 4 or 5 bits used.
// - DMA block is the receive threshold, 32 by default; status byte counts in.
// - Optional receive buffer limit tracking raises an interrupt when reached.
`default_nettype none

package fifo_chan_pkg;
    // ----------------------------------------------------------------
    // Sizes
    // ----------------------------------------------------------------
    localparam int unsigned POOL_BYTES = 32;
    localparam int unsigned FIFO_DEPTH = 64;
    localparam int unsigned PTR_W = 6;
    localparam int unsigned CNT_W = 7;
    localparam int unsigned RXW = 11;
    localparam logic [CNT_W-1:0] POOL_CNT = 7'h20;
    localparam logic [CNT_W-1:0] FULL_CNT = 7'h40;

    // ----------------------------------------------------------------
    // Register offsets (byte addresses)
    // ----------------------------------------------------------------
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_CMD = 8'h04;
    localparam logic [7:0] OFS_TXDATA = 8'h08;
    localparam logic [7:0] OFS_RXDATA = 8'h0C;
    localparam logic [7:0] OFS_STATUS = 8'h10;
    localparam logic [7:0] OFS_COUNT = 8'h14;
    localparam logic [7:0] OFS_TERM = 8'h18;
    localparam logic [7:0] OFS_PREAMB = 8'h1C;
    localparam logic [7:0] OFS_MAXBUF = 8'h20;

    // ----------------------------------------------------------------
    // Control fields, reset value, command bits
    // ----------------------------------------------------------------
    localparam int unsigned CTRL_MODE = 0;
    localparam int unsigned CTRL_PU = 2;
    localparam int unsigned CTRL_OSCILLATOR_POWERDOWN = 3;
    localparam int unsigned CTRL_SHPDIS = 4;
    localparam int unsigned CTRL_SHARED_FLAG_ENABLE = 5;
    localparam int unsigned CTRL_CRCEN = 6;
    localparam int unsigned CTRL_TERM_CHAR_DETECT_ENABLE = 7;
    localparam int unsigned CTRL_PREEN = 8;
    localparam int unsigned CTRL_RX_THRESHOLD_FIELD = 9;
    localparam int unsigned CTRL_STAAPP = 11;
    localparam int unsigned CTRL_CHST = 12;
    localparam logic [12:0] CTRL_RESET = 13'h0008;
    localparam int unsigned CMD_FRAME = 0;
    localparam int unsigned CMD_IFRAME = 1;
    localparam int unsigned CMD_MSGEND = 2;
    localparam int unsigned CMD_TXRES = 3;
    localparam int unsigned CMD_RX_FIFO_READ_CMD = 4;
    localparam int unsigned CMD_RMC = 5;
    localparam int unsigned CMD_RXDMA = 6;
    localparam int unsigned MAXBUF_DIS = 12;
    localparam int unsigned STA_OVF = 5;
    localparam int unsigned CNTH_OVF = 7;

    localparam logic [1:0] MODE_HDLC = 2'h0;
    localparam logic [1:0] MODE_ASYNC = 2'h1;
    localparam logic [1:0] MODE_BISYNC = 2'h2;
    localparam logic [1:0] MODE_PPP = 2'h3;

    // ----------------------------------------------------------------
    // Line-side symbol kinds, transmit states
    // ----------------------------------------------------------------
    localparam logic [2:0] KIND_DATA = 3'h0;
    localparam logic [2:0] KIND_PRE = 3'h1;
    localparam logic [2:0] KIND_CRC = 3'h2;
    localparam logic [2:0] KIND_FLAG = 3'h3;
    localparam logic [2:0] KIND_ABORT = 3'h4;
    localparam logic [2:0] KIND_IDLE = 3'h5;

    typedef enum logic [2:0] {
        TX_IDLE = 3'b000,
        TX_PRE = 3'b001,
        TX_DATA = 3'b010,
        TX_CRC = 3'b011,
        TX_FLAG = 3'b100,
        TX_END = 3'b101
    } tx_state_t;

    // Threshold code 0 is the 32-byte default
    function automatic logic [CNT_W-1:0] rx_thresh(input logic [1:0] code);
        case (code)
            2'h0: rx_thresh = 7'h20;
            2'h1: rx_thresh = 7'h10;
            2'h2: rx_thresh = 7'h04;
            default: rx_thresh = 7'h02;
        endcase
    endfunction : rx_thresh
endpackage : fifo_chan_pkg

`default_nettype wire

// file: src/fifo_chan.sv
/*
 * One channel's transmit and receive FIFO data handling with an APB slave.
 * Assumes a line coder on clk that takes symbols by valid/ready and a line
 * decoder on clk that delivers received bytes and end strobes.
 */
// Implementation choices: the APB slave port and the register offsets.
`default_nettype none

module fifo_chan
    import fifo_chan_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Transmit symbols to line coder
    output logic tx_out_valid,
    input wire logic tx_out_ready,
    output logic [7:0] tx_out_data,
    output logic [2:0] tx_out_kind,
    // Received bytes from line decoder
    input wire logic rx_in_valid,
    input wire logic [7:0] rx_in_data,
    input wire logic rx_in_parity,
    input wire logic rx_in_perr,
    input wire logic rx_in_ferr,
    input wire logic rx_in_end,
    input wire logic [7:0] rx_in_status,
    // Event pulses
    output logic tx_pool_ready_irq,
    output logic tx_underrun_irq,
    output logic rx_pool_full_irq,
    output logic rx_message_end_irq,
    output logic term_char_irq,
    output logic rx_buffer_full_irq,
    // DMA requests and oscillator control
    output logic tx_dma_req,
    output logic rx_dma_req,
    output logic osc_power_on,
    output logic shaper_on
);
    typedef struct packed {
        logic [12:0] ctrl;
        logic [7:0] term_char;
        logic [7:0] pre_num;
        logic [12:0] maxbuf;
        logic [FIFO_DEPTH-1:0][7:0] tmem;
        logic [PTR_W-1:0] twp;
        logic [PTR_W-1:0] trp;
        logic [CNT_W-1:0] tcnt;
        tx_state_t tstate;
        logic eom;
        logic pend;
        logic pend_eom;
        logic [7:0] pre_left;
        logic [FIFO_DEPTH-1:0][RXW-1:0] rmem;
        logic [PTR_W-1:0] rwp;
        logic [PTR_W-1:0] rrp;
        logic [CNT_W-1:0] rcnt;
        logic [CNT_W-1:0] blk;
        logic [11:0] msg_len;
        logic [7:0] cnt_low;
        logic [7:0] cnt_high;
        logic [7:0] rx_status_byte;
        logic ovf;
        logic done;
        logic [11:0] bufcnt;
        logic bufhold;
        logic [31:0] prdata;
        logic pslverr;
        logic [5:0] irq;
    } state_t;

    state_t s_r;
    state_t s_nxt;

    // ----------------------------------------------------------------
    // Decodes
    // ----------------------------------------------------------------
    logic [1:0] mode;
    logic pkt_mode;
    logic run;
    logic wr;
    logic rd;
    logic mapped;
    logic [CNT_W-1:0] thr;

    assign mode = s_r.ctrl[CTRL_MODE +: 2];
    assign pkt_mode = (mode == MODE_HDLC) || (mode == MODE_PPP);
    assign run = s_r.ctrl[CTRL_PU];
    assign wr = psel && penable && pwrite;
    assign rd = psel && penable && !pwrite;
    assign thr = rx_thresh(s_r.ctrl[CTRL_RX_THRESHOLD_FIELD +: 2]);
    assign mapped = (paddr <= OFS_MAXBUF) && (paddr[1:0] == 2'h0);

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        logic tpush;
        logic tpop;
        logic rpush;
        logic rpop;
        logic start;
        logic end_cond;
        logic [RXW-1:0] rword;
        logic [CNT_W-1:0] blk1;
        tpush = 1'b0;
        tpop = 1'b0;
        rpush = 1'b0;
        rpop = 1'b0;
        start = 1'b0;
        end_cond = 1'b0;
        rword = '0;
        blk1 = s_r.blk + 7'h01;
        s_nxt = s_r;
        s_nxt.irq = '0;

        // Register writes stay possible while powered down
        if (wr) begin
            case (paddr)
                OFS_CTRL: s_nxt.ctrl = pwdata[12:0];
                OFS_TERM: s_nxt.term_char = pwdata[7:0];
                OFS_PREAMB: s_nxt.pre_num = pwdata[7:0];
                OFS_MAXBUF: s_nxt.maxbuf = pwdata[12:0];
                OFS_TXDATA: tpush = (s_r.tcnt != FULL_CNT);
                default: ;
            endcase
        end
        if (rd && paddr == OFS_RXDATA && s_r.rcnt != '0) begin
            rpop = 1'b1;
        end

        // Transmit commands
        if (run && wr && paddr == OFS_CMD) begin
            if (pwdata[CMD_TXRES]) begin
                s_nxt.tstate = TX_IDLE;
                s_nxt.eom = 1'b0;
                s_nxt.pend = 1'b0;
                s_nxt.twp = s_r.trp;
                s_nxt.tcnt = '0;
            end else begin
                // Async has no I-frame
                if (pwdata[CMD_FRAME] || (pwdata[CMD_IFRAME] && mode != MODE_ASYNC)) begin
                    if (s_r.tstate == TX_IDLE) begin
                        start = 1'b1;
                        s_nxt.eom = pwdata[CMD_MSGEND];
                    end else begin
                        s_nxt.pend = 1'b1;
                        s_nxt.pend_eom = pwdata[CMD_MSGEND];
                    end
                end else if (pwdata[CMD_MSGEND]) begin
                    s_nxt.eom = 1'b1;
                end
            end
        end

        // Transmit sequencer
        if (run && !start) begin
            case (s_r.tstate)
                TX_PRE: begin
                    if (tx_out_ready) begin
                        s_nxt.pre_left = s_r.pre_left - 8'h01;
                        if (s_r.pre_left <= 8'h01) begin
                            s_nxt.tstate = TX_DATA;
                        end
                    end
                end
                TX_DATA: begin
                    if (s_r.tcnt != '0) begin
                        tpop = tx_out_ready;
                    end else if (s_r.eom) begin
                        if (pkt_mode || (mode == MODE_BISYNC && s_r.ctrl[CTRL_CRCEN])) begin
                            s_nxt.tstate = TX_CRC;
                        end else begin
                            s_nxt.tstate = TX_IDLE;
                            s_nxt.eom = 1'b0;
                        end
                    end else if (mode != MODE_ASYNC) begin
                        // Abort in packet modes, idle fill in bisync
                        s_nxt.tstate = TX_END;
                        s_nxt.irq[1] = 1'b1;
                    end
                end
                TX_CRC: begin
                    if (tx_out_ready) begin
                        s_nxt.eom = 1'b0;
                        if (!pkt_mode) begin
                            s_nxt.tstate = TX_IDLE;
                        end else if (s_r.ctrl[CTRL_SHARED_FLAG_ENABLE] && s_r.pend) begin
                            // Next opening flag doubles as this closing one
                            start = 1'b1;
                            s_nxt.pend = 1'b0;
                            s_nxt.eom = s_r.pend_eom;
                        end else begin
                            s_nxt.tstate = TX_FLAG;
                        end
                    end
                end
                TX_FLAG, TX_END: begin
                    if (tx_out_ready) begin
                        s_nxt.tstate = TX_IDLE;
                        s_nxt.eom = 1'b0;
                        if (s_r.pend) begin
                            start = 1'b1;
                            s_nxt.pend = 1'b0;
                            s_nxt.eom = s_r.pend_eom;
                        end
                    end
                end
                default: ;
            endcase
        end
        if (start) begin
            s_nxt.pre_left = s_r.pre_num;
            s_nxt.tstate = (s_r.ctrl[CTRL_PREEN] && s_r.pre_num != 8'h00) ? TX_PRE : TX_DATA;
        end

        if (tpush) begin
            s_nxt.tmem[s_r.twp] = pwdata[7:0];
            s_nxt.twp = s_r.twp + 6'h01;
        end
        if (tpop) begin
            s_nxt.trp = s_r.trp + 6'h01;
        end
        if (!(run && wr && paddr == OFS_CMD && pwdata[CMD_TXRES])) begin
            s_nxt.tcnt = s_r.tcnt + 7'(tpush) - 7'(tpop);
        end
        // Pool ready, repeated until message end is known
        if (run && !s_nxt.eom && s_nxt.tstate != TX_IDLE && s_nxt.tcnt <= POOL_CNT
            && (start || (s_r.tcnt > POOL_CNT))) begin
            s_nxt.irq[0] = 1'b1;
        end

        // Receive path
        if (run) begin
            if (rx_in_valid) begin
                rword[7:0] = rx_in_data;
                if (s_r.ctrl[CTRL_CHST] && !pkt_mode) begin
                    rword[10:8] = {rx_in_parity, rx_in_perr, rx_in_ferr && mode == MODE_ASYNC};
                end
                if (s_r.rcnt == FULL_CNT) begin
                    s_nxt.ovf = 1'b1;
                end else begin
                    rpush = 1'b1;
                end
                s_nxt.msg_len = s_r.msg_len + 12'h001;
                s_nxt.blk = blk1;
                if (!pkt_mode && s_r.ctrl[CTRL_TERM_CHAR_DETECT_ENABLE] && rx_in_data == s_r.term_char) begin
                    s_nxt.irq[4] = 1'b1;
                    end_cond = 1'b1;
                end else if (blk1 == thr) begin
                    s_nxt.irq[2] = 1'b1;
                    s_nxt.blk = '0;
                end
            end else if (rx_in_end && pkt_mode) begin
                rword[7:0] = rx_in_status;
                rword[STA_OVF] = rx_in_status[STA_OVF] | s_r.ovf;
                s_nxt.rx_status_byte = rword[7:0];
                if (s_r.ctrl[CTRL_STAAPP]) begin
                    rpush = (s_r.rcnt != FULL_CNT);
                end
                s_nxt.cnt_low = 8'(s_r.msg_len + 12'(s_r.ctrl[CTRL_STAAPP]));
                s_nxt.cnt_high = {s_r.ovf, 3'h0, 4'((s_r.msg_len + 12'(s_r.ctrl[CTRL_STAAPP])) >> 8)};
                s_nxt.irq[3] = 1'b1;
                s_nxt.done = 1'b1;
                s_nxt.msg_len = '0;
                s_nxt.blk = '0;
            end
            if (wr && paddr == OFS_CMD && pwdata[CMD_RX_FIFO_READ_CMD] && !pkt_mode) begin
                end_cond = 1'b1;
            end
            if (end_cond) begin
                s_nxt.cnt_low = 8'(rx_in_valid ? blk1 : s_r.blk);
                s_nxt.cnt_high = 8'h00;
                s_nxt.blk = '0;
                s_nxt.msg_len = '0;
                s_nxt.done = 1'b1;
            end
            if (wr && paddr == OFS_CMD && pwdata[CMD_RMC]) begin
                s_nxt.done = 1'b0;
                s_nxt.ovf = rx_in_valid && s_r.rcnt == FULL_CNT;
            end
        end
        if (rpush) begin
            s_nxt.rmem[s_r.rwp] = rword;
            s_nxt.rwp = s_r.rwp + 6'h01;
        end
        if (rpop) begin
            s_nxt.rrp = s_r.rrp + 6'h01;
            s_nxt.bufcnt = s_r.bufcnt + 12'h001;
        end
        s_nxt.rcnt = s_r.rcnt + 7'(rpush) - 7'(rpop);

        // Receive buffer limit
        if (run && rpop && !s_r.maxbuf[MAXBUF_DIS] && s_nxt.bufcnt == s_r.maxbuf[11:0]) begin
            s_nxt.bufhold = 1'b1;
            s_nxt.irq[5] = 1'b1;
        end
        if (run && wr && paddr == OFS_CMD && pwdata[CMD_RXDMA]) begin
            s_nxt.bufhold = 1'b0;
            s_nxt.bufcnt = '0;
        end

        // Read data captured in the setup phase, held through access
        if (psel && !penable) begin
            s_nxt.pslverr = !mapped;
            case (paddr)
                OFS_CTRL: s_nxt.prdata = {19'h0, s_r.ctrl};
                OFS_RXDATA: s_nxt.prdata = {21'h0, s_r.rmem[s_r.rrp]};
                OFS_STATUS: s_nxt.prdata = {11'h0, s_r.bufhold, s_r.tstate, s_r.done, s_r.ovf,
                    s_r.rcnt, s_r.tcnt <= POOL_CNT, s_r.tcnt};
                OFS_COUNT: s_nxt.prdata = {8'h0, s_r.rx_status_byte, s_r.cnt_high, s_r.cnt_low};
                OFS_TERM: s_nxt.prdata = {24'h0, s_r.term_char};
                OFS_PREAMB: s_nxt.prdata = {24'h0, s_r.pre_num};
                OFS_MAXBUF: s_nxt.prdata = {19'h0, s_r.maxbuf};
                default: s_nxt.prdata = 32'h0000_0000;
            endcase
        end
        // Power-down: no event leaves the channel
        if (!run) begin
            s_nxt.irq = '0;
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            s_r <= '0;
            s_r.ctrl <= CTRL_RESET;
            s_r.tstate <= TX_IDLE;
        end else begin
            s_r <= s_nxt;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign prdata = s_r.prdata;
    assign pready = 1'b1;
    assign pslverr = s_r.pslverr && psel && penable;
    assign tx_out_valid = run && (s_r.tstate == TX_PRE || s_r.tstate == TX_CRC || s_r.tstate == TX_FLAG
        || s_r.tstate == TX_END || (s_r.tstate == TX_DATA && s_r.tcnt != '0));
    assign tx_out_data = s_r.tmem[s_r.trp];
    always_comb begin
        case (s_r.tstate)
            TX_PRE: tx_out_kind = KIND_PRE;
            TX_CRC: tx_out_kind = KIND_CRC;
            TX_FLAG: tx_out_kind = KIND_FLAG;
            TX_END: tx_out_kind = pkt_mode ? KIND_ABORT : KIND_IDLE;
            default: tx_out_kind = KIND_DATA;
        endcase
    end
    assign tx_pool_ready_irq = s_r.irq[0];
    assign tx_underrun_irq = s_r.irq[1];
    assign rx_pool_full_irq = s_r.irq[2];
    assign rx_message_end_irq = s_r.irq[3];
    assign term_char_irq = s_r.irq[4];
    assign rx_buffer_full_irq = s_r.irq[5];
    // Receive DMA moves one threshold-sized block at a time; transmit DMA requests while at most 32 bytes are queued
    assign tx_dma_req = run && s_r.tstate != TX_IDLE && !s_r.eom && s_r.tcnt <= POOL_CNT;
    assign rx_dma_req = run && !s_r.bufhold && (s_r.rcnt >= thr || (s_r.done && s_r.rcnt != '0));
    assign osc_power_on = !s_r.ctrl[CTRL_OSCILLATOR_POWERDOWN];
    assign shaper_on = osc_power_on && !s_r.ctrl[CTRL_SHPDIS];

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    sequence txres_write_s;
        run && wr && paddr == OFS_CMD && pwdata[CMD_TXRES];
    endsequence

    pool_ready_level_a: assert property (tx_pool_ready_irq |-> s_r.tcnt <= POOL_CNT && !s_r.eom)
        else $error("pool ready raised above one pool");
    powerdown_quiet_a: assert property (!$past(run) |-> s_r.irq == '0)
        else $error("event forwarded while powered down");
    underrun_end_a: assert property (tx_underrun_irq |-> s_r.tstate == TX_END && $past(s_r.tcnt) == '0)
        else $error("underrun without empty fifo");
    tx_reset_flush_a: assert property (txres_write_s |=> s_r.tstate == TX_IDLE && s_r.tcnt == '0)
        else $error("transmit reset did not abort");
    rx_overflow_a: assert property (run && rx_in_valid && s_r.rcnt == FULL_CNT |=> s_r.ovf ##1 1'b1)
        else $error("overflow not flagged");
    term_char_a: assert property (term_char_irq |-> $past(rx_in_data) == $past(s_r.term_char)
        && !$past(pkt_mode) && s_r.done)
        else $error("termination event without match");
    msg_end_len_a: assert property (run && pkt_mode && rx_in_end && !rx_in_valid && !s_r.ctrl[CTRL_STAAPP]
        |=> rx_message_end_irq && s_r.cnt_low == $past(s_r.msg_len[7:0]))
        else $error("message length not stored");
    shaper_osc_a: assert property (shaper_on |-> osc_power_on && !s_r.ctrl[CTRL_OSCILLATOR_POWERDOWN])
        else $error("shaper used without oscillator");
    unmapped_err_a: assert property (psel && !penable && !mapped ##1 psel && penable |-> pslverr)
        else $error("unmapped access not refused");
endmodule : fifo_chan

`default_nettype wire

// file: tb/line_partner.sv
/* Line coder stand-in: takes symbols with random stalls and logs them.
   Assumes the channel's symbol valid/ready port on the same clock. */
`default_nettype none
module line_partner (
    // Symbol port
    input wire logic clk,
    input wire logic tx_out_valid,
    input wire logic [7:0] tx_out_data,
    input wire logic [2:0] tx_out_kind,
    output logic tx_out_ready
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [10:0] log_q[$];
    initial tx_out_ready = 1'b0;
    // Random stalls exercise holding each symbol until taken; only taken symbols are logged, nothing is checked
    always @(posedge clk) begin
        if (tx_out_valid && tx_out_ready)
            log_q.push_back({tx_out_kind, tx_out_data});
        tx_out_ready <= 1'($urandom_range(0, 1));
    end
endmodule : line_partner
`default_nettype wire

// file: tb/serial_channel_fifo_data_handling_tb.sv
/* Bench for the channel FIFO block: APB master, line partner, rx strobes.
   Assumes the package and the line partner are compiled first. */
`default_nettype none
module serial_channel_fifo_data_handling_tb;
    import fifo_chan_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 0, nrst = 0, psel = 0, penable = 0, pwrite = 0, rx_v = 0, rx_e = 0;
    logic [7:0] paddr = '0, rx_d = '0;
    logic [31:0] pwdata = '0, prdata, rd;
    logic pready, pslverr, er, tv, tr, osc, shp;
    logic [7:0] td;
    logic [2:0] tk;
    logic [14:0] ks;
    logic [5:0] irq;
    logic [7:0] b[3];
    int ic[6] = '{default: 0};
    int error_cnt = 0;
    int n_tests = 0;
    always #5 clk = ~clk;
    always @(posedge clk) foreach (ic[i]) ic[i] += int'(irq[i]);
    fifo_chan dut (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .tx_out_valid(tv), .tx_out_ready(tr), .tx_out_data(td), .tx_out_kind(tk),
        .rx_in_valid(rx_v), .rx_in_data(rx_d), .rx_in_parity(rx_d[0]), .rx_in_perr(rx_d[1]),
        .rx_in_ferr(rx_d[2]), .rx_in_end(rx_e), .rx_in_status(8'h00),
        .tx_pool_ready_irq(irq[0]), .tx_underrun_irq(irq[1]), .rx_pool_full_irq(irq[2]),
        .rx_message_end_irq(irq[3]), .term_char_irq(irq[4]), .rx_buffer_full_irq(irq[5]),
        .tx_dma_req(), .rx_dma_req(), .osc_power_on(osc), .shaper_on(shp));
    line_partner p (.clk(clk), .tx_out_valid(tv), .tx_out_data(td), .tx_out_kind(tk),
        .tx_out_ready(tr));
    function automatic int thr(input logic [1:0] code);
        return (code == 2'h0) ? 32 : (code == 2'h1) ? 16 : (code == 2'h2) ? 4 : 2;
    endfunction : thr
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic rx(input logic v, input logic e, input logic [7:0] d);
        @(posedge clk);
        rx_v <= v;
        rx_e <= e;
        rx_d <= d;
        @(posedge clk);
        rx_v <= 1'b0;
        rx_e <= 1'b0;
    endtask : rx
    // Symbol kinds of the first n logged symbols, oldest in the top bits
    task automatic kinds(input int n);
        for (int i = 0; i < 300 && p.log_q.size() < n; i++) @(posedge clk);
        repeat (3) @(posedge clk);
        ks = '0;
        for (int i = 0; i < n; i++) ks = {ks[11:0], p.log_q[i][10:8]};
    endtask : kinds
    task automatic wrap_up;
        $display("checks=%0d errors=%0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : wrap_up
    initial begin
        void'($urandom(32'h7A68));
        repeat (8) @(posedge clk);
        nrst <= 1'b1;
        apb(1'b0, OFS_CTRL, '0);
        chk(rd, 32'h8);
        chk(osc, 1'b0);
        // Set up while powered down: HDLC, 2-byte threshold, preambles
        apb(1'b1, OFS_CTRL, 32'h700);
        apb(1'b1, OFS_PREAMB, 32'h2);
        b[0] = 8'($urandom);
        apb(1'b1, OFS_TXDATA, 32'(b[0]));
        apb(1'b1, OFS_CMD, 32'h5);
        repeat (20) @(posedge clk);
        chk(p.log_q.size(), 0);
        apb(1'b1, OFS_CTRL, 32'h704);
        chk({osc, shp}, 2'h3);
        apb(1'b1, OFS_CMD, 32'h5);
        kinds(5);
        chk(ks, {KIND_PRE, KIND_PRE, KIND_DATA, KIND_CRC, KIND_FLAG});
        chk(p.log_q[2][7:0], b[0]);
        // No message end: the single byte drains, then abort
        apb(1'b1, OFS_CTRL, 32'h604);
        p.log_q.delete();
        apb(1'b1, OFS_TXDATA, 32'(b[0]));
        apb(1'b1, OFS_CMD, 32'h1);
        kinds(2);
        chk(ks[5:0], {KIND_DATA, KIND_ABORT});
        chk(ic[1], 1);
        chk(ic[0] > 0, 1'b1);
        foreach (b[i]) begin
            b[i] = 8'($urandom);
            rx(1'b1, 1'b0, b[i]);
        end
        repeat (2) @(posedge clk);
        chk(ic[2], 3 / thr(2'h3));
        rx(1'b0, 1'b1, 8'h00);
        repeat (2) @(posedge clk);
        chk(ic[3], 1);
        apb(1'b0, OFS_COUNT, '0);
        chk(rd[23:0], 24'h000003);
        apb(1'b0, OFS_RXDATA, '0);
        chk(rd[7:0], b[0]);
        apb(1'b1, OFS_CMD, 32'h20);
        // Async with termination character, then a read command end
        apb(1'b1, OFS_TERM, 32'h5A);
        apb(1'b1, OFS_CTRL, 32'h685);
        rx(1'b1, 1'b0, 8'h5A);
        repeat (2) @(posedge clk);
        chk(ic[4], 1);
        rx(1'b1, 1'b0, 8'h11);
        apb(1'b1, OFS_CMD, 32'h10);
        apb(1'b0, OFS_COUNT, '0);
        chk(rd[7:0], 8'h01);
        apb(1'b0, 8'h24, '0);
        chk(er, 1'b1);
        wrap_up();
    end
    initial begin
        #200us;
        error_cnt++;
        wrap_up();
    end
endmodule : serial_channel_fifo_data_handling_tb
`default_nettype wire
